// >>> hdl/tag_i2c_pkg.sv
// Purpose: shared constants and carriers for the tag serial front end
// Assumes: single 10 MHz clock, synchronous active-high reset
// Notes:   select byte and beat layouts are packed structs
`default_nettype none
package tag_i2c_pkg;
  // select byte fixed bits b2..b1
  localparam logic [1:0] SEL_FIXED_ONES = 2'h3;
  // bits per byte on the serial link
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [1:0] BYTE_IDX_SEL   = 2'h0;
  localparam logic [1:0] BYTE_IDX_AHI   = 2'h1;
  localparam logic [1:0] BYTE_IDX_ALO   = 2'h2;
  localparam logic [1:0] BYTE_IDX_DATA  = 2'h3;
  // reset values
  localparam logic [2:0]  SYNC_RST      = 3'h0;
  // bus lines idle high behind the pull-up; resetting them low fakes an edge
  localparam logic [2:0]  SYNC_BUS_RST  = 3'h7;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [7:0]  SHIFT_RST     = 8'h00;

  typedef struct packed {
    logic [3:0] type_id;
    logic       chip_enable_select_bit;
    logic [1:0] fixed_ones;
    logic       read_not_write;
  } select_byte_t;

  typedef struct packed {
    logic        chip_enable_select_bit;
    logic [15:0] addr;
    logic [7:0]  data;
  } wr_beat_t;

  typedef struct packed {
    logic busy_mode;
    logic harvest_enable;
  } config_t;

  typedef struct packed {
    logic vcc_powered;
    logic rf_write_active;
    logic rf_cmd_active;
    logic field_sufficient;
  } rf_status_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_TXLOAD
  } ser_state_t;
endpackage
`default_nettype wire

// >>> hdl/tag_i2c_front.sv
// Purpose: serial slave front end, status pin and harvest gate of a tag
// Assumes: scl, sda and por level arrive asynchronously; rf and cfg on clk
// Notes:   sda and the status pin are open drain, low or released only
//
// Behaviour
// - bus bits timed only by serial clock edges
// - data line only pulled low or released
// - one status pin, write or busy mode
// - status low for whole write or command
// - status only asserted on external supply
// - status pin open drain, pulls low only
// - harvest off unless enabled and field sufficient
// - below power-on threshold, ignore and never ack
// - crossing threshold resets logic, enters standby
// - falling below threshold stops responding immediately
// - standby after stop, or after pending write
// - select: id, chip enable, ones, rw
// - bytes sent most significant bit first
// - chip enable bit chosen by master, not strap
// - address high byte then low byte
// - ack in ninth bit of written bytes
`default_nettype none
module tag_i2c_front
  import tag_i2c_pkg::*;
#(
  // arbitrary value, not a real maker code
  parameter logic [3:0] DEV_TYPE_ID = 4'h5
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // serial pins
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // supply monitor
  input  wire logic                    por_ok_in,
  // rf side and configuration
  input  wire tag_i2c_pkg::config_t    cfg,
  input  wire tag_i2c_pkg::rf_status_t rf,
  output logic                         rf_activity_flag_out,
  output logic                         rf_activity_flag_oe,
  output logic                         harvest_drive,
  // memory side
  input  wire logic                    write_pending,
  input  wire logic [7:0]              rd_data,
  output logic                         rd_req,
  output logic [15:0]                  rd_addr,
  output logic                         wr_valid,
  output tag_i2c_pkg::wr_beat_t        wr_beat,
  output logic                         standby
);
  import tag_i2c_pkg::*;

  // input synchronisers, level taken once stages two and three agree
  logic [2:0] scl_s_q, sda_s_q, por_s_q;
  logic       scl_f_q, sda_f_q, por_f_q;
  logic       scl_f_d, sda_f_d, por_f_d;

  always_comb
  begin
    scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
    por_f_d = (por_s_q[1] == por_s_q[2]) ? por_s_q[2] : por_f_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_s_q <= SYNC_BUS_RST;
      sda_s_q <= SYNC_BUS_RST;
      por_s_q <= SYNC_RST;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      por_f_q <= 1'b0;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      por_s_q <= {por_s_q[1:0], por_ok_in};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
      por_f_q <= por_f_d;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, por_rise;
  assign scl_rise  = scl_f_d & ~scl_f_q;
  assign scl_fall  = ~scl_f_d & scl_f_q;
  assign start_det = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  assign stop_det  = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;
  assign por_rise  = por_f_d & ~por_f_q;

  // serial engine
  ser_state_t   st_q, st_d;
  logic [3:0]   bit_q, bit_d;
  logic [1:0]   idx_q, idx_d;
  logic [7:0]   sh_q, sh_d;
  logic [15:0]  addr_q, addr_d;
  logic         ce_q, ce_d, rd_q, rd_d;
  logic         oe_q, oe_d, rdreq_q, rdreq_d, wrv_q, wrv_d;
  wr_beat_t     beat_q, beat_d;
  logic         stby_q, stby_d, pend_q, pend_d;
  select_byte_t sel;
  logic         sel_match;

  assign sel = select_byte_t'(sh_q);
  // select byte layout, chip enable taken from the byte
  assign sel_match = (sel.type_id == DEV_TYPE_ID) && (sel.fixed_ones == SEL_FIXED_ONES);

  always_comb
  begin
    st_d    = st_q;
    bit_d   = bit_q;
    idx_d   = idx_q;
    sh_d    = sh_q;
    addr_d  = addr_q;
    ce_d    = ce_q;
    rd_d    = rd_q;
    oe_d    = oe_q;
    rdreq_d = 1'b0;
    wrv_d   = 1'b0;
    beat_d  = beat_q;
    stby_d  = stby_q;
    pend_d  = pend_q;
    // standby once the pending write has finished
    if (pend_q && !write_pending)
    begin
      stby_d = 1'b1;
      pend_d = 1'b0;
    end
    if (start_det)
    begin
      st_d   = ST_RX;
      bit_d  = 4'h0;
      idx_d  = BYTE_IDX_SEL;
      oe_d   = 1'b0;
      stby_d = 1'b0;
      pend_d = 1'b0;
    end
    else if (stop_det)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      // standby after stop unless a write is in flight
      if (write_pending)
        pend_d = 1'b1;
      else
        stby_d = 1'b1;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE: ;
        ST_RX:
        begin
          // shift in most significant bit first
          if (scl_rise && bit_q < BYTE_BITS)
          begin
            sh_d  = {sh_q[6:0], sda_f_q};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == BYTE_BITS)
          begin
            if (idx_q == BYTE_IDX_SEL && !sel_match)
              st_d = ST_IDLE;
            else
            begin
              // ack driven through the ninth bit
              st_d = ST_ACK;
              oe_d = 1'b1;
              unique case (idx_q)
                BYTE_IDX_SEL:
                begin
                  ce_d = sel.chip_enable_select_bit;
                  rd_d    = sel.read_not_write;
                  rdreq_d = sel.read_not_write;
                end
                // high address byte first, then low
                BYTE_IDX_AHI: addr_d[15:8] = sh_q;
                BYTE_IDX_ALO: addr_d[7:0]  = sh_q;
                BYTE_IDX_DATA:
                begin
                  wrv_d  = 1'b1;
                  beat_d = '{chip_enable_select_bit: ce_q, addr: addr_q, data: sh_q};
                  addr_d = addr_q + 16'h0001;
                end
              endcase
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_d = 4'h0;
            if (idx_q != BYTE_IDX_DATA)
              idx_d = idx_q + 2'h1;
            if (idx_q == BYTE_IDX_SEL && rd_q)
            begin
              st_d = ST_TX;
              sh_d = rd_data;
              oe_d = ~rd_data[7];
            end
            else
            begin
              st_d = ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
            bit_d = bit_q + 4'h1;
          else if (scl_fall)
          begin
            if (bit_q == BYTE_BITS)
            begin
              st_d = ST_TXACK;
              oe_d = 1'b0;
            end
            else
            begin
              // pull low for zero, release for one
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            if (sda_f_q)
              st_d = ST_IDLE;
            else
            begin
              st_d    = ST_TXLOAD;
              addr_d  = addr_q + 16'h0001;
              rdreq_d = 1'b1;
            end
          end
        end
        ST_TXLOAD:
        begin
          if (scl_fall)
          begin
            st_d  = ST_TX;
            bit_d = 4'h0;
            sh_d  = rd_data;
            oe_d  = ~rd_data[7];
          end
        end
      endcase
    end
    // crossing the threshold resets and enters standby
    if (!por_f_d || por_rise)
    begin
      st_d    = ST_IDLE;
      oe_d    = 1'b0;
      rdreq_d = 1'b0;
      wrv_d   = 1'b0;
      pend_d  = 1'b0;
      stby_d  = por_f_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q    <= ST_IDLE;
      bit_q   <= 4'h0;
      idx_q   <= BYTE_IDX_SEL;
      sh_q    <= SHIFT_RST;
      addr_q  <= ADDR_RST;
      ce_q    <= 1'b0;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
      rdreq_q <= 1'b0;
      wrv_q   <= 1'b0;
      beat_q  <= '0;
      stby_q  <= 1'b0;
      pend_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      bit_q   <= bit_d;
      idx_q   <= idx_d;
      sh_q    <= sh_d;
      addr_q  <= addr_d;
      ce_q    <= ce_d;
      rd_q    <= rd_d;
      oe_q    <= oe_d;
      rdreq_q <= rdreq_d;
      wrv_q   <= wrv_d;
      beat_q  <= beat_d;
      stby_q  <= stby_d;
      pend_q  <= pend_d;
    end
  end

  // status pin and harvest gate; rf lines already on clk
  logic flag_q, flag_d, harv_q, harv_d, low_q;

  always_comb
  begin
    // mode picks write or command activity, only on vcc
    flag_d = rf.vcc_powered & (cfg.busy_mode ? rf.rf_cmd_active : rf.rf_write_active);
    // harvest only when enabled and field strong enough
    harv_d = cfg.harvest_enable & rf.field_sufficient;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flag_q <= 1'b0;
      harv_q <= 1'b0;
      low_q  <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      harv_q <= harv_d;
      low_q  <= 1'b0;
    end
  end

  // open drain level is always low, enable does the work
  assign sda_out              = low_q;
  assign sda_oe               = oe_q;
  assign rf_activity_flag_out = low_q;
  assign rf_activity_flag_oe  = flag_q;
  assign harvest_drive        = harv_q;
  assign rd_req               = rdreq_q;
  assign rd_addr              = addr_q;
  assign wr_valid             = wrv_q;
  assign wr_beat              = beat_q;
  assign standby              = stby_q;

  por_gate_a: assert property (@(posedge clk) disable iff (srst)
    !por_f_q |=> !sda_oe && !wr_valid) else $error("bus answered below threshold");
  por_reset_a: assert property (@(posedge clk) disable iff (srst)
    $rose(por_f_q) |-> st_q == ST_IDLE && standby) else $error("no standby on power-up");
  flag_supply_a: assert property (@(posedge clk) disable iff (srst)
    !rf.vcc_powered |=> !rf_activity_flag_oe) else $error("status pin on rf power");
  flag_busy_a: assert property (@(posedge clk) disable iff (srst)
    rf.vcc_powered && cfg.busy_mode && rf.rf_cmd_active |=> rf_activity_flag_oe)
    else $error("busy not flagged");
  flag_wip_a: assert property (@(posedge clk) disable iff (srst)
    rf.vcc_powered && !cfg.busy_mode |=> rf_activity_flag_oe == $past(rf.rf_write_active))
    else $error("write mode not followed");
  harvest_gate_a: assert property (@(posedge clk) disable iff (srst)
    !(cfg.harvest_enable && rf.field_sufficient) |=> !harvest_drive)
    else $error("harvest driven while off");
  open_drain_a: assert property (@(posedge clk) disable iff (srst)
    sda_out == 1'b0 && rf_activity_flag_out == 1'b0) else $error("open drain drove high");
  ack_ninth_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_RX && scl_fall && bit_q == BYTE_BITS && idx_q != BYTE_IDX_SEL
    && por_f_d && !start_det && !stop_det |=> sda_oe && st_q == ST_ACK)
    else $error("missing ack");
  bad_select_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_RX && scl_fall && bit_q == BYTE_BITS && idx_q == BYTE_IDX_SEL
    && !sel_match && !start_det |=> st_q == ST_IDLE && !sda_oe)
    else $error("foreign select acked");
  stop_standby_a: assert property (@(posedge clk) disable iff (srst)
    stop_det && !write_pending && por_f_d |=> standby) else $error("no standby after stop");
endmodule
`default_nettype wire

// >>> test/i2c_master_model.sv
// Purpose: bus master model driving the tag front end
// Assumes: pins change only at falling clk edges
// Notes:   8-clock phases, well over the 5-clock minimum
`default_nettype none
module i2c_master_model (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda_wire,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold();
    repeat (8) @(negedge clk);
  endtask
  task automatic start();
    @(negedge clk);
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  // released line floats to the pull-up, never a stale value
  task automatic clock_bit(input logic d, output logic seen);
    sda_low = d;
    hold();
    scl = 1'b1;
    hold();
    seen = sda_wire;
    scl = 1'b0;
    hold();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(~b[i], s);
    clock_bit(1'b0, s);
    acked = ~s;
  endtask
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(1'b0, b[i]);
    clock_bit(ack_it, s);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for the tag serial front end
// Assumes: master model drives the bus; bench plays memory and rf side
// Notes:   type id 4'h5 is arbitrary, handed to the design
`default_nettype none
module tb_top
  import tag_i2c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] TYPE_ID = 4'h5;
  logic       clk, srst, por_ok_in, write_pending, scl, sda_low;
  logic       sda_out, sda_oe, flag_out, flag_oe, harvest_drive;
  logic       rd_req, wr_valid, standby;
  logic [7:0] rd_data;
  logic [15:0] rd_addr;
  config_t    cfg;
  rf_status_t rf;
  wr_beat_t   wr_beat;
  wr_beat_t   beats[$];
  int         err_total, samples_checked, cycles;
  wire logic  sda_wire;
  // pull-up: low only while a party pulls
  assign sda_wire = ~(sda_oe | sda_low);

  tag_i2c_front #(.DEV_TYPE_ID(TYPE_ID)) u_tag_i2c_front (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .por_ok_in(por_ok_in),
    .cfg(cfg), .rf(rf), .rf_activity_flag_out(flag_out),
    .rf_activity_flag_oe(flag_oe), .harvest_drive(harvest_drive),
    .write_pending(write_pending), .rd_data(rd_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_beat(wr_beat), .standby(standby));
  i2c_master_model u_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

  always #50 clk = ~clk;
  // memory answers a read request with a pattern of its address
  always @(negedge clk)
    if (srst)
      rd_data <= 8'h00;
    else if (rd_req === 1'b1)
      rd_data <= rd_addr[7:0] ^ 8'h5a;
  always @(negedge clk)
    if (wr_valid === 1'b1)
      beats.push_back(wr_beat);
  // ceiling well above the ~5k cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    chk_bit(got === exp, 1'b1, m);
  endtask
  task automatic chk_beat(input wr_beat_t got, input wr_beat_t exp);
    chk_bit(got === exp, 1'b1, "written beat");
  endtask
  function automatic logic [7:0] sel(input logic ce, input logic rw);
    return {TYPE_ID, ce, 2'h3, rw};
  endfunction

  task automatic test_power();
    logic a;
    u_master.start();
    u_master.send_byte(sel(1'b0, 1'b0), a);
    chk_bit(a, 1'b0, "ack below threshold");
    u_master.stop();
    chk_bit(standby, 1'b0, "standby early");
    por_ok_in = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit(standby, 1'b1, "no standby");
    u_master.start();
    u_master.send_byte(sel(1'b0, 1'b0), a);
    chk_bit(a, 1'b1, "select ack");
    por_ok_in = 1'b0;
    repeat (8) @(negedge clk);
    u_master.send_byte(8'h00, a);
    chk_bit(a, 1'b0, "ack after drop");
    u_master.stop();
    por_ok_in = 1'b1;
    repeat (8) @(negedge clk);
    $display("test power done");
  endtask

  task automatic test_write();
    logic a;
    beats.delete();
    u_master.start();
    u_master.send_byte(sel(1'b1, 1'b0), a);
    chk_bit(a, 1'b1, "select ack");
    u_master.send_byte(8'h12, a);
    chk_bit(a, 1'b1, "addr hi ack");
    u_master.send_byte(8'h34, a);
    chk_bit(a, 1'b1, "addr lo ack");
    write_pending = 1'b1;
    u_master.send_byte(8'ha5, a);
    chk_bit(a, 1'b1, "data ack");
    u_master.send_byte(8'h3c, a);
    chk_bit(a, 1'b1, "data ack");
    u_master.stop();
    repeat (8) @(negedge clk);
    chk_bit(standby, 1'b0, "standby while pending");
    write_pending = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(standby, 1'b1, "no standby after write");
    chk_bit(beats.size() == 2, 1'b1, "beat count");
    chk_beat(beats[0], {1'b1, 16'h1234, 8'ha5});
    chk_beat(beats[1], {1'b1, 16'h1235, 8'h3c});
    $display("test write done");
  endtask

  task automatic test_bad_select();
    logic a;
    logic [7:0] bad[3] = '{{4'h6, 4'h6}, {TYPE_ID, 4'h4}, {TYPE_ID, 4'h3}};
    foreach (bad[i])
    begin
      u_master.start();
      u_master.send_byte(bad[i], a);
      chk_bit(a, 1'b0, "bad select ack");
      u_master.send_byte(8'h00, a);
      chk_bit(a, 1'b0, "ack after bad");
      u_master.stop();
    end
    $display("test bad select done");
  endtask

  task automatic test_read();
    logic a;
    logic [7:0] d;
    u_master.start();
    u_master.send_byte(sel(1'b0, 1'b0), a);
    u_master.send_byte(8'h00, a);
    u_master.send_byte(8'h40, a);
    u_master.start();
    u_master.send_byte(sel(1'b0, 1'b1), a);
    chk_bit(a, 1'b1, "read select ack");
    u_master.recv_byte(1'b1, d);
    chk_byte(d, 8'h40 ^ 8'h5a, "read byte 0");
    u_master.recv_byte(1'b0, d);
    chk_byte(d, 8'h41 ^ 8'h5a, "read byte 1");
    u_master.stop();
    repeat (3) @(negedge clk);
    chk_bit(sda_oe, 1'b0, "line held");
    $display("test read done");
  endtask

  task automatic test_status();
    logic e;
    for (int i = 0; i < 64; i++)
    begin
      {cfg, rf} = i[5:0];
      repeat (3) @(negedge clk);
      e = rf.vcc_powered & (cfg.busy_mode ? rf.rf_cmd_active : rf.rf_write_active);
      chk_bit(flag_oe, e, "status pin");
      chk_bit(flag_out, 1'b0, "status drives high");
      chk_bit(harvest_drive, cfg.harvest_enable & rf.field_sufficient, "harvest");
      chk_bit(sda_out, 1'b0, "data drives high");
    end
    // reader drops the field fully, nothing rf-driven stays on
    cfg = 2'h3;
    rf  = '{vcc_powered: 1'b1, default: 1'b0};
    repeat (3) @(negedge clk);
    chk_bit(flag_oe, 1'b0, "status with field off");
    chk_bit(harvest_drive, 1'b0, "harvest with field off");
    $display("test status done");
  endtask

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    por_ok_in = 1'b0;
    write_pending = 1'b0;
    cfg = '0;
    rf = '0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    test_power();
    test_write();
    test_bad_select();
    test_read();
    test_status();
    finish_test();
  end
endmodule
`default_nettype wire
